/* rtl/orps_sequencer.v */
// Programming, verifying and identifying sequencer for a one-time ROM
//
// Function
// - Program pulse nominal 100 us, 95-105 us.
// - Start at lowest address, step upward.
// - Raise core and programming supplies first.
// - First pass: one pulse each, no verify.
// - Second pass: read back and compare each.
// - On miscompare pulse again, verify each time.
// - Ten retries failed: stop, flag part failed.
// - Byte verified: next address until all checked.
// - Then lower both supplies to normal.
// - Final read of all bytes decides pass.
// - Core supply on first, off last.
// - Wait 150 ns after output enable before sampling.
// - Drive data only 130 ns after output enable off.
// - Identify: address low, bit nine high, select bit.
`timescale 1ns/10ps
`default_nettype none
`include "orps_defines.vh"
module orps_sequencer #(
  parameter         AW      = `ORPS_ADDR_W,
  parameter [31:0]  PW_CYC  = `ORPS_PW_CYC,
  parameter [AW-1:0] LAST_ADDR = {AW{1'b1}}
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             sys_rst,
  // User command side
  input  wire             start_prog,
  input  wire             start_id,
  output reg  [AW-1:0]    src_addr_q,
  input  wire [7:0]       src_data,
  output reg              busy_q,
  output reg              done_q,
  output reg              pass_q,
  output reg  [7:0]       id_maker_q,
  output reg  [7:0]       id_type_q,
  output reg  [3:0]       retry_cnt_q,
  // Supply control
  output reg              vcc_prog_en_q,
  output reg              vpp_prog_en_q,
  // Device pins
  output reg  [AW-1:0]    rom_addr_q,
  output reg              id_mode_high_voltage_pin_q,
  output reg              chip_en_n_q,
  output reg              out_en_n_q,
  output reg              program_strobe_n_q,
  output reg  [7:0]       data_lines_o_q,
  output reg              data_lines_oe_q,
  input  wire [7:0]       data_lines_i
);

  // States, one-hot
  localparam [12:0] S_IDLE  = 13'h0001;
  localparam [12:0] S_VCC   = 13'h0002;
  localparam [12:0] S_VPP   = 13'h0004;
  localparam [12:0] S_SETUP = 13'h0008;
  localparam [12:0] S_PULSE = 13'h0010;
  localparam [12:0] S_HOLD  = 13'h0020;
  localparam [12:0] S_RDOE  = 13'h0040;
  localparam [12:0] S_RDEND = 13'h0080;
  localparam [12:0] S_VPPOF = 13'h0100;
  localparam [12:0] S_VCCOF = 13'h0200;
  localparam [12:0] S_IDRD  = 13'h0400;
  localparam [12:0] S_DONE  = 13'h0800;
  localparam [12:0] S_FAIL  = 13'h1000;

  // Phases of the sequence
  localparam [1:0] P_FIRST  = 2'h0;
  localparam [1:0] P_VERIFY = 2'h1;
  localparam [1:0] P_FINAL  = 2'h2;
  localparam [1:0] P_ID     = 2'h3;

  localparam [31:0] SETUP_CYC = `ORPS_SETUP_CYC;
  localparam [31:0] OE_CYC    = `ORPS_OE_CYC;
  localparam [31:0] DFP_CYC   = `ORPS_DFP_CYC;

  reg [12:0] state_q;        // Current state
  reg [1:0]  phase_q;        // Current pass
  reg [31:0] tmr_q;          // Cycle timer
  reg        final_ok_q;     // All final reads matched so far

  // Address increment
  function [AW-1:0] next_addr;
    input [AW-1:0] a;
    begin
      next_addr = a + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Sequencer process
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= S_IDLE;
      phase_q <= P_FIRST;
      tmr_q <= 32'h0000_0000;
      final_ok_q <= 1'b0;
      src_addr_q <= {AW{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      id_maker_q <= 8'h00;
      id_type_q <= 8'h00;
      retry_cnt_q <= 4'h0;
      vcc_prog_en_q <= 1'b0;
      vpp_prog_en_q <= 1'b0;
      rom_addr_q <= {AW{1'b0}};
      id_mode_high_voltage_pin_q <= 1'b0;
      chip_en_n_q <= 1'b1;
      out_en_n_q <= 1'b1;
      program_strobe_n_q <= 1'b1;
      data_lines_o_q <= 8'h00;
      data_lines_oe_q <= 1'b0;
    end
    else
    begin
      tmr_q <= tmr_q + 32'h0000_0001;
      case (state_q)
        // Wait for a command
        S_IDLE:
        begin
          tmr_q <= 32'h0000_0000;
          if (start_prog)
          begin
            src_addr_q <= {AW{1'b0}};
            rom_addr_q <= {AW{1'b0}};
            phase_q <= P_FIRST;
            retry_cnt_q <= 4'h0;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            pass_q <= 1'b0;
            vcc_prog_en_q <= 1'b1;
            state_q <= S_VCC;
          end
          else if (start_id)
          begin
            rom_addr_q <= {AW{1'b0}};
            id_mode_high_voltage_pin_q <= 1'b1;
            phase_q <= P_ID;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            state_q <= S_SETUP;
          end
        end
        // Core supply settle, then programming supply
        S_VCC:
          if (tmr_q >= SETUP_CYC)
          begin
            vpp_prog_en_q <= 1'b1;
            tmr_q <= 32'h0000_0000;
            state_q <= S_VPP;
          end
        // Programming supply settle
        S_VPP:
          if (tmr_q >= SETUP_CYC)
          begin
            tmr_q <= 32'h0000_0000;
            state_q <= S_SETUP;
          end
        // Address/data setup before pulse or read
        S_SETUP:
        begin
          chip_en_n_q <= 1'b0;
          if (phase_q == P_FIRST || (phase_q == P_VERIFY && retry_cnt_q != 4'h0))
          begin
            data_lines_o_q <= src_data;
            data_lines_oe_q <= 1'b1;
          end
          if (tmr_q >= SETUP_CYC)
          begin
            tmr_q <= 32'h0000_0000;
            if (phase_q == P_ID)
            begin
              out_en_n_q <= 1'b0;
              state_q <= S_IDRD;
            end
            else if (data_lines_oe_q)
            begin
              out_en_n_q <= 1'b1;
              program_strobe_n_q <= 1'b0;
              state_q <= S_PULSE;
            end
            else
            begin
              out_en_n_q <= 1'b0;
              state_q <= S_RDOE;
            end
          end
        end
        // Program pulse
        S_PULSE:
          if (tmr_q >= PW_CYC - 32'h0000_0001)
          begin
            program_strobe_n_q <= 1'b1;
            tmr_q <= 32'h0000_0000;
            state_q <= S_HOLD;
          end
        // Data hold after pulse
        S_HOLD:
          if (tmr_q >= SETUP_CYC)
          begin
            data_lines_oe_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
            if (phase_q == P_FIRST)
            begin
              if (src_addr_q == LAST_ADDR)
              begin
                phase_q <= P_VERIFY;
                src_addr_q <= {AW{1'b0}};
                rom_addr_q <= {AW{1'b0}};
              end
              else
              begin
                src_addr_q <= next_addr(src_addr_q);
                rom_addr_q <= next_addr(rom_addr_q);
              end
              state_q <= S_SETUP;
            end
            else
            begin
              out_en_n_q <= 1'b0;
              state_q <= S_RDOE;
            end
          end
        // Wait for data valid, then compare
        S_RDOE:
          if (tmr_q >= OE_CYC)
          begin
            out_en_n_q <= 1'b1;
            tmr_q <= 32'h0000_0000;
            state_q <= S_RDEND;
            if (phase_q == P_FINAL)
            begin
              if (data_lines_i != src_data)
                final_ok_q <= 1'b0;
            end
            else if (data_lines_i == src_data)
            begin
              retry_cnt_q <= 4'h0;
            end
            else if (retry_cnt_q == `ORPS_MAX_RETRY)
            begin
              state_q <= S_FAIL;
            end
            else
            begin
              retry_cnt_q <= retry_cnt_q + 4'h1;
            end
          end
        // Release gap, then next step
        S_RDEND:
          if (tmr_q >= DFP_CYC)
          begin
            tmr_q <= 32'h0000_0000;
            if (retry_cnt_q != 4'h0)
              state_q <= S_SETUP;
            else if (src_addr_q == LAST_ADDR)
            begin
              if (phase_q == P_VERIFY)
              begin
                vpp_prog_en_q <= 1'b0;
                state_q <= S_VPPOF;
              end
              else
              begin
                pass_q <= final_ok_q;
                state_q <= S_DONE;
              end
            end
            else
            begin
              src_addr_q <= next_addr(src_addr_q);
              rom_addr_q <= next_addr(rom_addr_q);
              state_q <= S_SETUP;
            end
          end
        // Programming supply falls
        S_VPPOF:
          if (tmr_q >= SETUP_CYC)
          begin
            vcc_prog_en_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
            state_q <= S_VCCOF;
          end
        // Core supply falls, start final read pass
        S_VCCOF:
          if (tmr_q >= SETUP_CYC)
          begin
            phase_q <= P_FINAL;
            final_ok_q <= 1'b1;
            src_addr_q <= {AW{1'b0}};
            rom_addr_q <= {AW{1'b0}};
            tmr_q <= 32'h0000_0000;
            state_q <= S_SETUP;
          end
        // Identification reads, select bit chooses byte
        S_IDRD:
          if (tmr_q >= OE_CYC)
          begin
            tmr_q <= 32'h0000_0000;
            if (!rom_addr_q[0])
            begin
              id_maker_q <= data_lines_i;
              rom_addr_q <= {{(AW-1){1'b0}}, 1'b1};
            end
            else
            begin
              id_type_q <= data_lines_i;
              out_en_n_q <= 1'b1;
              id_mode_high_voltage_pin_q <= 1'b0;
              pass_q <= 1'b1;
              state_q <= S_DONE;
            end
          end
        // Failure: release everything, supplies down in order
        S_FAIL:
        begin
          pass_q <= 1'b0;
          if (vpp_prog_en_q)
          begin
            vpp_prog_en_q <= 1'b0;
            tmr_q <= 32'h0000_0000;
          end
          else if (tmr_q >= SETUP_CYC)
          begin
            vcc_prog_en_q <= 1'b0;
            state_q <= S_DONE;
          end
        end
        // Sequence ended, result stands until next start
        S_DONE:
        begin
          chip_en_n_q <= 1'b1;
          out_en_n_q <= 1'b1;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          tmr_q <= 32'h0000_0000;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* rtl/orps_defines.vh */
// Constants of the one-time ROM programming sequencer
`ifndef ORPS_DEFINES_VH
`define ORPS_DEFINES_VH
// Clock period in picoseconds (40 MHz)
`define ORPS_CLK_PS          32'h0000_61A8
// Program pulse nominal width in ns (100000), and its bounds (95000, 105000)
`define ORPS_PW_NOM_NS       32'h0001_86A0
`define ORPS_PW_MIN_NS       32'h0001_7318
`define ORPS_PW_MAX_NS       32'h0001_9A28
// Pulse cycles: nominal 100 us at 25 ns
`define ORPS_PW_CYC          ((`ORPS_PW_NOM_NS * 32'h0000_03E8) / `ORPS_CLK_PS)
// Data valid after output enable, 150 ns (least wait, rounded up)
`define ORPS_OE_NS           32'h0000_0096
`define ORPS_OE_CYC          ((`ORPS_OE_NS * 32'h0000_03E8 + `ORPS_CLK_PS - 32'h0000_0001) / `ORPS_CLK_PS)
// Data release after output enable off, 130 ns (least wait, rounded up)
`define ORPS_DFP_NS          32'h0000_0082
`define ORPS_DFP_CYC         ((`ORPS_DFP_NS * 32'h0000_03E8 + `ORPS_CLK_PS - 32'h0000_0001) / `ORPS_CLK_PS)
// Setup time for address, data, strobes and supplies, 2000 ns (rounded up)
`define ORPS_SETUP_NS        32'h0000_07D0
`define ORPS_SETUP_CYC       ((`ORPS_SETUP_NS * 32'h0000_03E8 + `ORPS_CLK_PS - 32'h0000_0001) / `ORPS_CLK_PS)
// Retry pulse limit per byte (ten)
`define ORPS_MAX_RETRY       4'hA
// Address width (128K locations)
`define ORPS_ADDR_W          17
// Address bit that carries the identification voltage
`define ORPS_ID_HV_BIT       9
`endif

/* dv/orps_sequencer_monitor.sv */
// Port checker for the ROM programming sequencer
`timescale 1ns/10ps
`default_nettype none
module orps_sequencer_monitor #(
  parameter int AW     = 17,
  parameter int PW_CYC = 8
) (
  // Clock and reset
  input wire logic          clk_sys,
  input wire logic          sys_rst,
  // Status
  input wire logic          busy_q,
  input wire logic          done_q,
  input wire logic [3:0]    retry_cnt_q,
  // Supplies and device pins
  input wire logic          vcc_prog_en_q,
  input wire logic          vpp_prog_en_q,
  input wire logic [AW-1:0] rom_addr_q,
  input wire logic          id_mode_high_voltage_pin_q,
  input wire logic          chip_en_n_q,
  input wire logic          out_en_n_q,
  input wire logic          program_strobe_n_q,
  input wire logic          data_lines_oe_q
);
  logic [31:0] low_q; // Strobe low cycles
  // Counts the length of each pulse
  always @(posedge clk_sys)
    low_q <= program_strobe_n_q ? 32'h0 : low_q + 32'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_pulse_width: assert property ($rose(program_strobe_n_q) |-> low_q == PW_CYC)
    else $error("pulse width wrong");
  chk_pulse_setup: assert property (!program_strobe_n_q |-> vpp_prog_en_q && vcc_prog_en_q
    && !chip_en_n_q && out_en_n_q && data_lines_oe_q)
    else $error("pulse without setup");
  chk_vcc_first: assert property (vpp_prog_en_q |-> vcc_prog_en_q)
    else $error("supply order");
  chk_done_supply: assert property (done_q |-> !vpp_prog_en_q && !vcc_prog_en_q && !busy_q)
    else $error("supplies high at end");
  chk_read_wait: assert property ($fell(out_en_n_q) |-> (!out_en_n_q)[*6])
    else $error("read too short");
  chk_float_gap: assert property ($rose(out_en_n_q) |-> (!data_lines_oe_q)[*6])
    else $error("drive too soon");
  chk_retry_limit: assert property (retry_cnt_q <= 4'hA)
    else $error("too many retries");
  chk_addr_step: assert property (busy_q && $changed(rom_addr_q) && !id_mode_high_voltage_pin_q
    |-> rom_addr_q == $past(rom_addr_q) + 1 || rom_addr_q == 0)
    else $error("address skip");
  chk_id_addr: assert property (id_mode_high_voltage_pin_q |-> rom_addr_q[AW-1:10] == 0
    && rom_addr_q[8:1] == 0 && !vpp_prog_en_q)
    else $error("id address");
  chk_retry_clear: assert property (busy_q && $changed(rom_addr_q) && !id_mode_high_voltage_pin_q
    |-> retry_cnt_q == 4'h0)
    else $error("retry count kept on new address");
endmodule
bind orps_sequencer orps_sequencer_monitor #(.AW(AW), .PW_CYC(PW_CYC)) orps_sequencer_monitor_i (.clk_sys, .sys_rst,
  .busy_q, .done_q, .retry_cnt_q, .vcc_prog_en_q, .vpp_prog_en_q, .rom_addr_q, .id_mode_high_voltage_pin_q,
  .chip_en_n_q, .out_en_n_q, .program_strobe_n_q, .data_lines_oe_q);
`default_nettype wire

/* dv/orps_rom_model.sv */
// Behavioural model of the one-time ROM
`timescale 1ns/10ps
`default_nettype none
module orps_rom_model #(
  parameter int       AW    = 17,
  parameter bit [7:0] MAKER = 8'hA5, // Arbitrary value
  parameter bit [7:0] KIND  = 8'h3C  // Arbitrary value
) (
  // Clock ages the output enable
  input  wire logic          clk_sys,
  // Device pins
  input  wire logic [AW-1:0] addr,
  input  wire logic          id_hv,
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          pgm_n,
  input  wire logic          vcc_on,
  input  wire logic          vpp_on,
  input  wire logic [7:0]    din,
  output logic      [7:0]    dout
);
  logic [7:0] mem [4];      // Array
  int         need [4];     // Pulses a byte needs
  int         hits [4];     // Pulses seen
  int         age = 0;      // Cycles with output on
  logic [7:0] last = 8'h00; // Last line value
  // only a powered, qualified pulse programs
  always @(posedge pgm_n)
    if (!ce_n && oe_n && vpp_on && vcc_on)
    begin
      hits[addr[1:0]]++;
      if (hits[addr[1:0]] >= need[addr[1:0]])
        mem[addr[1:0]] &= din;
    end
  // Ages the read and remembers the lines
  always @(posedge clk_sys)
  begin
    age <= (ce_n || oe_n) ? 0 : age + 1;
    last <= dout;
  end
  always @*
    if (ce_n || oe_n || age < 5 || (id_hv && addr[AW-1:1] != 0))
      dout = ~last;
    else
      dout = id_hv ? (addr[0] ? KIND : MAKER) : mem[addr[1:0]];
endmodule
`default_nettype wire

/* dv/orps_sequencer_bench.sv */
// Self-checking bench for the ROM programming sequencer
`timescale 1ns/10ps
`default_nettype none
module orps_sequencer_bench;
  localparam bit [7:0] MAKER = 8'hA5; // Arbitrary value
  localparam bit [7:0] KIND  = 8'h3C; // Arbitrary value
  // Stimulus and bookkeeping
  logic        clk_sys    = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        start_prog = 1'b0;
  logic        start_id   = 1'b0;
  logic [7:0]  src [4];
  logic [17:0] exp_q [$];
  logic [17:0] note;
  logic        done_prev  = 1'b0;
  int          seed       = 91;
  int          failures   = 0;
  int          checks     = 0;
  // Design outputs, the model output and the read bus
  wire [16:0] src_addr_q;
  wire [16:0] rom_addr_q;
  wire [7:0]  id_maker_q;
  wire [7:0]  id_type_q;
  wire [7:0]  data_lines_o_q;
  wire [7:0]  dev_dout;
  wire [7:0]  data_lines_i;
  wire [3:0]  retry_cnt_q;
  wire        busy_q, done_q, pass_q, vcc_prog_en_q, vpp_prog_en_q;
  wire        id_mode_high_voltage_pin_q, chip_en_n_q, out_en_n_q, program_strobe_n_q, data_lines_oe_q;
  always #12.5 clk_sys = ~clk_sys;
  assign data_lines_i = data_lines_oe_q ? data_lines_o_q : dev_dout;
  orps_sequencer #(.PW_CYC(32'd8), .LAST_ADDR(17'h00003)) orps_sequencer_i (.clk_sys, .sys_rst, .start_prog,
    .start_id, .src_addr_q, .src_data(src[src_addr_q[1:0]]), .busy_q, .done_q, .pass_q, .id_maker_q, .id_type_q,
    .retry_cnt_q, .vcc_prog_en_q, .vpp_prog_en_q, .rom_addr_q, .id_mode_high_voltage_pin_q, .chip_en_n_q,
    .out_en_n_q, .program_strobe_n_q, .data_lines_o_q, .data_lines_oe_q, .data_lines_i);
  orps_rom_model #(.MAKER(MAKER), .KIND(KIND)) orps_rom_model_i (.clk_sys, .addr(rom_addr_q),
    .id_hv(id_mode_high_voltage_pin_q), .ce_n(chip_en_n_q), .oe_n(out_en_n_q), .pgm_n(program_strobe_n_q),
    .vcc_on(vcc_prog_en_q), .vpp_on(vpp_prog_en_q), .din(data_lines_o_q), .dout(dev_dout));
  // Counts one comparison
  task automatic check(input bit ok, input string what);
  begin
    checks++;
    if (!ok)
    begin
      failures++;
      $display("BAD %0t %s", $time, what);
    end
  end
  endtask
  // Fresh part with pulses needed per byte
  task automatic load(input int nd [4]);
  begin
    for (int i = 0; i < 4; i++)
    begin
      orps_rom_model_i.need[i] = nd[i];
      orps_rom_model_i.hits[i] = 0;
      orps_rom_model_i.mem[i] = 8'hFF;
      src[i] = 8'($random(seed)) & 8'hFE;
    end
  end
  endtask
  // One sequence, with an optional ignored start
  task automatic run(input bit id, input bit [17:0] exp, input int poke);
    int n;
  begin
    exp_q.push_back(exp);
    @(negedge clk_sys);
    start_id = id;
    start_prog = !id;
    @(negedge clk_sys);
    start_id = 1'b0;
    start_prog = 1'b0;
    if (poke > 0)
    begin
      repeat (poke) @(negedge clk_sys);
      start_id = 1'b1;
      @(negedge clk_sys);
      start_id = 1'b0;
    end
    @(negedge clk_sys);
    n = 0;
    while (done_q !== 1'b1 && n < 20000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(n < 20000, "no finish");
  end
  endtask
  // Verdict
  task automatic summarize;
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // Takes the oldest note when a sequence ends
  always @(negedge clk_sys)
  begin
    if (done_q === 1'b1 && !done_prev && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check(pass_q === note[16], "result");
      if (note[17])
        check({id_maker_q, id_type_q} === note[15:0], "codes");
    end
    done_prev = done_q;
  end
  // Main sequence
  initial
  begin
    load('{1, 3, 11, 2});
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    run(1'b0, 18'h10000, 1 + {$random(seed)} % 40);
    for (int i = 0; i < 4; i++)
    begin
      check(orps_rom_model_i.mem[i] === src[i], "array");
      check(orps_rom_model_i.hits[i] === orps_rom_model_i.need[i], "pulse count");
    end
    $display("test slow bytes done");
    run(1'b1, {2'b11, MAKER, KIND}, 0);
    $display("test identify done");
    load('{1, 12, 1, 2});
    run(1'b0, 18'h00000, 0);
    check(orps_rom_model_i.hits[3] === 1, "ran on");
    $display("test failed part done");
    load('{2, 1, 1, 1});
    run(1'b0, 18'h10000, 0);
    $display("test reprogram done");
    summarize;
  end
  // Watchdog
  initial
  begin
    #2000000;
    failures++;
    $display("BAD %0t watchdog", $time);
    summarize;
  end
endmodule
`default_nettype wire
